/* include/uac_pkg.sv */
// Constants, field layout and carrier types of the ultrasonic front-end configuration bank
package uac_pkg;

  // System clock and default listening window
  localparam int          CLK_FREQ_MHZ       = 20;
  localparam int          LISTEN_TIME_US     = 400;
  localparam int          LISTEN_CYCLES_DFLT = LISTEN_TIME_US * CLK_FREQ_MHZ;

  // Register addresses (6-bit serial address space)
  localparam logic [5:0]  ADDR_AVG_RX        = 6'h01;
  localparam logic [5:0]  ADDR_CHAN_MODE     = 6'h02;
  localparam logic [5:0]  ADDR_TEMP_ECHO     = 6'h03;

  // Values after reset
  localparam logic [7:0]  RST_AVG_RX         = 8'h40;
  localparam logic [7:0]  RST_CHAN_MODE      = 8'h00;
  localparam logic [7:0]  RST_TEMP_ECHO      = 8'h03;
  localparam logic [7:0]  RD_UNMAPPED        = 8'h00;

  // Averaging / receive register fields
  localparam int          AVG_HI             = 5;
  localparam int          AVG_LO             = 3;
  localparam int          RX_HI              = 2;
  localparam int          RX_LO              = 0;

  // Channel / mode register fields
  localparam int          CMS_BIT            = 7;
  localparam int          MTYPE_BIT          = 6;
  localparam int          DAMP_BIT           = 5;
  localparam int          SWAP_BIT           = 4;
  localparam int          PINSEL_BIT         = 3;
  localparam int          SWCH_BIT           = 2;
  localparam int          FTM_HI             = 1;
  localparam int          FTM_LO             = 0;

  // Temperature / echo register fields
  localparam int          TCH_BIT            = 6;
  localparam int          STYPE_BIT          = 5;
  localparam int          TDIV_BIT           = 4;
  localparam int          BLANK_BIT          = 3;
  localparam int          ECHO_HI            = 2;
  localparam int          ECHO_LO            = 0;

  // Decoded values
  localparam logic [5:0]  RX_FREE_COUNT      = 6'h20;
  localparam logic [1:0]  FTM_MODE2          = 2'h2;
  localparam logic [1:0]  FTM_RESERVED       = 2'h3;
  localparam logic [2:0]  TEMP_DIV8_CODE     = 3'h2;

  // Serial frame layout
  localparam int          CMD_WRITE_BIT      = 6;
  localparam logic [4:0]  SPI_CMD_BITS       = 5'h08;
  localparam logic [4:0]  SPI_FRAME_BITS     = 5'h10;

  // Register write request from the serial port
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
  } uac_wr_type;

  // Configuration in force for the running measurement
  typedef struct packed {
    logic       common_mode_ext;
    logic       meas_temp;
    logic       damping;
    logic [1:0] flight_time_mode;
    logic       channel;
    logic       temp_rtd1_only;
    logic       sensor_pt500;
    logic [2:0] temp_div_code;
    logic       blanking;
    logic [2:0] echo_threshold_code;
    logic [2:0] average_cycle_code;
    logic [5:0] expected_stops;
  } uac_cfg_type;

  // Measurement sequencer states, Gray along idle-listen-done
  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'b00,
    SEQ_LISTEN = 2'b01,
    SEQ_DONE   = 2'b11
  } uac_seq_type;

endpackage

/* rtl/uac_config_regs.sv */
// Configuration bank of the ultrasonic front end with trigger-aligned apply
//
// Function
// - Averaging code 0..7 selects 1 to 128 cycles, doubling per step.
// - Receive code 1..7 expects that many events, one stop pulse each.
// - Receive code 0 counts nothing and passes 32 stop pulses.
// - Channel/mode bit 7 picks internal (0) or external (1) common mode.
// - Measurement type bit: 0 time of flight, 1 temperature.
// - Damping bit: 0 burst damping off, 1 on.
// - Swap bit enables automatic channel swap, only in flight mode two.
// - Pin-select bit takes the active channel from the select pin.
// - With pin select set, swap and software channel bits are ignored.
// - Software channel bit: 0 channel one, 1 channel two.
// - Flight mode codes 0..2; code 3 reserved, host must not write it.
// - Temperature channel bit: 0 reference and both RTDs, 1 reference and RTD1.
// - Sensor type bit: 0 selects 1000-ohm, 1 selects 500-ohm platinum.
// - Temperature divider: 0 divides by 8, 1 reuses transmit divider.
// - Blanking bit enables power blanking in time-of-flight measurements.
// - Echo threshold code 0..7 maps -35 mV to -1500 mV below common mode.
// - Temperature/echo register resets to 0x03.
// - Short window raises timeout, returns idle, sets error, drives error low.
// - Mode two stays 2^code triggers per channel, then swaps if enabled.
`timescale 1ns/100ps
module uac_config_regs #(
  parameter int LISTEN_CYCLES = uac_pkg::LISTEN_CYCLES_DFLT  // Receive window in cycles
) (
  input  wire logic           SYS_CLK,             // 20 MHz system clock
  input  wire logic           SRST,                // Synchronous reset, high
  input  wire logic           SPI_SCLK,            // Serial clock
  input  wire logic           SPI_CSB_N,           // Serial select, low active
  input  wire logic           SPI_SDI,             // Serial data in
  output logic                SPI_SDO,             // Serial data out
  output logic                SPI_SDO_OE_N,        // SDO drive enable, low active
  input  wire logic           MEAS_TRIGGER,        // Rising edge starts a measurement
  input  wire logic           RX_EVENT,            // Qualified echo event pulse
  input  wire logic           CHANNEL_SELECT_PIN,  // External channel choice
  input  wire logic [2:0]     TRANSMIT_DIVIDER,    // Transmit divider code
  input  wire logic           ERROR_CLEAR,         // Clears the error flag
  input  wire logic           STATE_CLEAR,         // Aborts and resets averaging
  output uac_pkg::uac_cfg_type ACTIVE_CFG,         // Settings of this measurement
  output logic                STOP_PULSE,          // One pulse per received event
  output logic                MEAS_BUSY,           // Measurement window open
  output logic                MEAS_DONE,           // Window ended complete
  output logic                TEMP_CLK_EN,         // Temperature clock enable pulse
  output logic                ERROR_FLAG,          // Sticky timeout error
  output logic                ERROR_OUTPUT_LOW_N   // Error pin, low on error
);
  import uac_pkg::*;

  initial begin
    if (LISTEN_CYCLES < 1 || LISTEN_CYCLES > 65535) begin
      $error("LISTEN_CYCLES out of range");
    end
  end

  // Expected stop count from the receive code
  function automatic logic [5:0] rx_expected(input logic [2:0] code);
    if (code == 3'h0) begin
      return RX_FREE_COUNT;
    end
    return {3'h0, code};
  endfunction

  // Last index of an averaging run of 2^code triggers
  function automatic logic [6:0] avg_last(input logic [2:0] code);
    logic [7:0] len;
    len = 8'h01 << code;
    return 7'(len - 8'h01);
  endfunction

  // Ratio minus one of a divide by 2^(code+1)
  function automatic logic [7:0] div_last(input logic [2:0] code);
    logic [8:0] len;
    len = 9'h002 << code;
    return 8'(len - 9'h001);
  endfunction

  // Serial port
  logic [5:0] rd_addr;
  logic [7:0] rd_data;
  logic       wr_valid;
  uac_wr_type wr_req;

  uac_spi_target u_spi (
    .clk      (SYS_CLK),
    .srst     (SRST),
    .sclk     (SPI_SCLK),
    .csb_n    (SPI_CSB_N),
    .sdi      (SPI_SDI),
    .rd_data  (rd_data),
    .rd_addr  (rd_addr),
    .wr_valid (wr_valid),
    .wr_req   (wr_req),
    .sdo      (SPI_SDO),
    .sdo_oe_n (SPI_SDO_OE_N)
  );

  // Register file state
  logic [7:0] avg_rx_ff, nxt_avg_rx;
  logic [7:0] chan_mode_ff, nxt_chan_mode;
  logic [7:0] temp_echo_ff, nxt_temp_echo;

  // Register writes by address
  always_comb begin
    nxt_avg_rx    = avg_rx_ff;
    nxt_chan_mode = chan_mode_ff;
    nxt_temp_echo = temp_echo_ff;
    if (wr_valid) begin
      case (wr_req.addr)
        ADDR_AVG_RX:    nxt_avg_rx    = wr_req.data;
        ADDR_CHAN_MODE: nxt_chan_mode = wr_req.data;
        ADDR_TEMP_ECHO: nxt_temp_echo = wr_req.data;
        default:        nxt_avg_rx    = avg_rx_ff;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      avg_rx_ff    <= RST_AVG_RX;
      chan_mode_ff <= RST_CHAN_MODE;
      temp_echo_ff <= RST_TEMP_ECHO;
    end else begin
      avg_rx_ff    <= nxt_avg_rx;
      chan_mode_ff <= nxt_chan_mode;
      temp_echo_ff <= nxt_temp_echo;
    end
  end

  // Read-back mux, unmapped reads as zero
  always_comb begin
    case (rd_addr)
      ADDR_AVG_RX:    rd_data = avg_rx_ff;
      ADDR_CHAN_MODE: rd_data = chan_mode_ff;
      ADDR_TEMP_ECHO: rd_data = temp_echo_ff;
      default:        rd_data = RD_UNMAPPED;
    endcase
  end

  // Field views of the programmed registers
  logic [1:0] ftm_eff;
  logic       mode2, pin_sel, swap_en, sw_chan;
  assign ftm_eff = (chan_mode_ff[FTM_HI:FTM_LO] == FTM_RESERVED) ? 2'h0
                   : chan_mode_ff[FTM_HI:FTM_LO];
  assign mode2   = (ftm_eff == FTM_MODE2);
  assign pin_sel = chan_mode_ff[PINSEL_BIT];
  assign swap_en = chan_mode_ff[SWAP_BIT] & mode2 & ~pin_sel;
  assign sw_chan = chan_mode_ff[SWCH_BIT];

  // Trigger edge and measurement sequencer
  uac_cfg_type cfg_ff, nxt_cfg;
  logic trig_q_ff, seq_busy, seq_done, seq_timeout, stop_pulse, start;
  assign start = MEAS_TRIGGER & ~trig_q_ff & ~seq_busy & ~STATE_CLEAR;

  uac_meas_seq #(
    .LISTEN_CYCLES (LISTEN_CYCLES)
  ) u_seq (
    .clk        (SYS_CLK),
    .srst       (SRST),
    .start      (start),
    .abort      (STATE_CLEAR),
    .stop_event (RX_EVENT),
    .expected   (cfg_ff.expected_stops),
    .stop_pulse (stop_pulse),
    .busy       (seq_busy),
    .done       (seq_done),
    .timeout    (seq_timeout)
  );

  // Averaging run and channel swap state
  logic [6:0]  avg_cnt_ff, nxt_avg_cnt;
  logic        swap_ff, nxt_swap;
  logic        chan_now;

  // Channel chosen for the next trigger
  always_comb begin
    if (pin_sel) begin
      chan_now = CHANNEL_SELECT_PIN;
    end else if (swap_en) begin
      chan_now = sw_chan ^ swap_ff;
    end else begin
      chan_now = sw_chan;
    end
  end

  // Snapshot on each accepted trigger; averaging advances in flight mode two only
  always_comb begin
    nxt_cfg     = cfg_ff;
    nxt_avg_cnt = avg_cnt_ff;
    nxt_swap    = swap_ff;
    if (STATE_CLEAR) begin
      nxt_avg_cnt = 7'h00;
      nxt_swap    = 1'b0;
    end else if (start) begin
      nxt_cfg.common_mode_ext     = chan_mode_ff[CMS_BIT];
      nxt_cfg.meas_temp           = chan_mode_ff[MTYPE_BIT];
      nxt_cfg.damping             = chan_mode_ff[DAMP_BIT];
      nxt_cfg.flight_time_mode    = ftm_eff;
      nxt_cfg.channel             = chan_now;
      nxt_cfg.temp_rtd1_only      = temp_echo_ff[TCH_BIT];
      nxt_cfg.sensor_pt500        = temp_echo_ff[STYPE_BIT];
      nxt_cfg.temp_div_code       = temp_echo_ff[TDIV_BIT] ? TRANSMIT_DIVIDER
                                    : TEMP_DIV8_CODE;
      nxt_cfg.blanking            = temp_echo_ff[BLANK_BIT]
                                    & ~chan_mode_ff[MTYPE_BIT];
      nxt_cfg.echo_threshold_code = temp_echo_ff[ECHO_HI:ECHO_LO];
      nxt_cfg.average_cycle_code  = avg_rx_ff[AVG_HI:AVG_LO];
      nxt_cfg.expected_stops      = rx_expected(avg_rx_ff[RX_HI:RX_LO]);
      if (mode2) begin
        if (avg_cnt_ff >= avg_last(avg_rx_ff[AVG_HI:AVG_LO])) begin
          nxt_avg_cnt = 7'h00;
          nxt_swap    = swap_ff ^ swap_en;
        end else begin
          nxt_avg_cnt = avg_cnt_ff + 7'h01;
        end
      end
    end
  end

  // Snapshot and averaging flops
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      trig_q_ff  <= 1'b0;
      avg_cnt_ff <= 7'h00;
      swap_ff    <= 1'b0;
      cfg_ff     <= '{temp_div_code: TEMP_DIV8_CODE,
                      echo_threshold_code: RST_TEMP_ECHO[ECHO_HI:ECHO_LO],
                      expected_stops: RX_FREE_COUNT,
                      default: '0};
    end else begin
      trig_q_ff  <= MEAS_TRIGGER;
      avg_cnt_ff <= nxt_avg_cnt;
      swap_ff    <= nxt_swap;
      cfg_ff     <= nxt_cfg;
    end
  end

  // Temperature clock enable divider and error flag
  logic [7:0] div_ff, nxt_div;
  logic       div_en_ff, nxt_div_en, err_ff, nxt_err;

  always_comb begin
    nxt_div    = 8'h00;
    nxt_div_en = 1'b0;
    if (seq_busy && cfg_ff.meas_temp) begin
      if (div_ff >= div_last(cfg_ff.temp_div_code)) begin
        nxt_div_en = 1'b1;
      end else begin
        nxt_div = div_ff + 8'h01;
      end
    end
    // Timeout sets, clear removes; set wins
    nxt_err = (err_ff & ~ERROR_CLEAR) | seq_timeout;
  end

  // Divider and error flops
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      div_ff    <= 8'h00;
      div_en_ff <= 1'b0;
      err_ff    <= 1'b0;
    end else begin
      div_ff    <= nxt_div;
      div_en_ff <= nxt_div_en;
      err_ff    <= nxt_err;
    end
  end

  // Outputs
  assign ACTIVE_CFG         = cfg_ff;
  assign STOP_PULSE         = stop_pulse;
  assign MEAS_BUSY          = seq_busy;
  assign MEAS_DONE          = seq_done;
  assign TEMP_CLK_EN        = div_en_ff;
  assign ERROR_FLAG         = err_ff;
  assign ERROR_OUTPUT_LOW_N = ~err_ff;
endmodule // uac_config_regs

/* rtl/uac_meas_seq.sv */
// Receive-window sequencer: forwards stop events and times out the window
`timescale 1ns/100ps
module uac_meas_seq #(
  parameter int LISTEN_CYCLES = uac_pkg::LISTEN_CYCLES_DFLT  // Window length in cycles
) (
  input  wire logic       clk,         // System clock
  input  wire logic       srst,        // Synchronous reset
  input  wire logic       start,       // Begin a listening window
  input  wire logic       abort,       // Drop back to idle
  input  wire logic       stop_event,  // Qualified receive event
  input  wire logic [5:0] expected,    // Stops that end the window
  output logic            stop_pulse,  // One stop pulse per event
  output logic            busy,        // Window open
  output logic            done,        // Window ended complete
  output logic            timeout      // Window ended short
);
  import uac_pkg::*;

  localparam int TW = $clog2(LISTEN_CYCLES + 1);

  initial begin
    if (LISTEN_CYCLES < 1 || LISTEN_CYCLES > 65535) begin
      $error("LISTEN_CYCLES out of range");
    end
  end

  uac_seq_type st_ff, nxt_st;
  logic [TW-1:0] tmr_ff, nxt_tmr;
  logic [5:0]    evt_ff, nxt_evt;
  logic          stp_ff, nxt_stp, to_ff, nxt_to;

  // Window control
  always_comb begin
    nxt_st  = st_ff;
    nxt_tmr = tmr_ff;
    nxt_evt = evt_ff;
    nxt_stp = 1'b0;
    nxt_to  = 1'b0;
    case (st_ff)
      SEQ_IDLE: begin
        if (start && !abort) begin
          nxt_st  = SEQ_LISTEN;
          nxt_tmr = '0;
          nxt_evt = 6'h00;
        end
      end
      SEQ_LISTEN: begin
        if (abort) begin
          nxt_st  = SEQ_IDLE;
        end else if (stop_event) begin
          nxt_stp = 1'b1;
          nxt_evt = evt_ff + 6'h01;
          if (evt_ff + 6'h01 == expected) begin
            nxt_st = SEQ_DONE;
          end
        end else if (tmr_ff == TW'(LISTEN_CYCLES - 1)) begin
          nxt_st  = SEQ_IDLE;
          nxt_to  = 1'b1;
        end else begin
          nxt_tmr = tmr_ff + TW'(1);
        end
      end
      SEQ_DONE: begin
        nxt_st = SEQ_IDLE;
      end
      default: begin
        nxt_st = SEQ_IDLE;
      end
    endcase
  end

  // Window registers
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff  <= SEQ_IDLE;
      tmr_ff <= '0;
      evt_ff <= 6'h00;
      stp_ff <= 1'b0;
      to_ff  <= 1'b0;
    end else begin
      st_ff  <= nxt_st;
      tmr_ff <= nxt_tmr;
      evt_ff <= nxt_evt;
      stp_ff <= nxt_stp;
      to_ff  <= nxt_to;
    end
  end

  assign stop_pulse = stp_ff;
  assign busy       = (st_ff != SEQ_IDLE);
  assign done       = (st_ff == SEQ_DONE);
  assign timeout    = to_ff;
endmodule // uac_meas_seq

/* rtl/uac_spi_target.sv */
// Byte-wide serial target: command byte then one data byte, mode 0
`timescale 1ns/100ps
module uac_spi_target (
  input  wire logic             clk,       // System clock
  input  wire logic             srst,      // Synchronous reset
  input  wire logic             sclk,      // Serial clock
  input  wire logic             csb_n,     // Chip select, low active
  input  wire logic             sdi,       // Serial data in
  input  wire logic [7:0]       rd_data,   // Read data for rd_addr
  output logic [5:0]            rd_addr,   // Addressed register
  output logic                  wr_valid,  // One-cycle write strobe
  output uac_pkg::uac_wr_type   wr_req,    // Write address and data
  output logic                  sdo,       // Serial data out
  output logic                  sdo_oe_n   // SDO drive enable, low active
);
  import uac_pkg::*;

  logic [7:0] sh_ff, nxt_sh, cmd_ff, nxt_cmd, tx_ff, nxt_tx;
  logic [4:0] cnt_ff, nxt_cnt;
  logic       sclk_q_ff, ld_ff, nxt_ld, wr_ff, nxt_wr;
  uac_wr_type req_ff, nxt_req;
  logic       rise, fall;

  assign rise = sclk & ~sclk_q_ff;
  assign fall = ~sclk & sclk_q_ff;

  // Shift, count and decode of one frame
  always_comb begin
    nxt_sh  = sh_ff;
    nxt_cmd = cmd_ff;
    nxt_tx  = tx_ff;
    nxt_cnt = cnt_ff;
    nxt_ld  = 1'b0;
    nxt_wr  = 1'b0;
    nxt_req = req_ff;
    if (csb_n) begin
      nxt_cnt = 5'h00;  // Deselect always ends the frame
    end else if (rise && cnt_ff != SPI_FRAME_BITS) begin
      nxt_sh  = {sh_ff[6:0], sdi};
      nxt_cnt = cnt_ff + 5'h01;
      if (cnt_ff == SPI_CMD_BITS - 5'h01) begin
        nxt_cmd = {sh_ff[6:0], sdi};
        nxt_ld  = 1'b1;
      end
      if (cnt_ff == SPI_FRAME_BITS - 5'h01 && cmd_ff[CMD_WRITE_BIT]) begin
        nxt_wr  = 1'b1;
        nxt_req = '{addr: cmd_ff[5:0], data: {sh_ff[6:0], sdi}};
      end
    end else if (fall && cnt_ff > SPI_CMD_BITS) begin
      nxt_tx  = {tx_ff[6:0], 1'b0};
    end
    if (ld_ff) begin
      nxt_tx  = rd_data;
    end
  end

  // Frame state registers
  always_ff @(posedge clk) begin
    if (srst) begin
      sh_ff     <= 8'h00;
      cmd_ff    <= 8'h00;
      tx_ff     <= 8'h00;
      cnt_ff    <= 5'h00;
      sclk_q_ff <= 1'b0;
      ld_ff     <= 1'b0;
      wr_ff     <= 1'b0;
      req_ff    <= '0;
    end else begin
      sh_ff     <= nxt_sh;
      cmd_ff    <= nxt_cmd;
      tx_ff     <= nxt_tx;
      cnt_ff    <= nxt_cnt;
      sclk_q_ff <= sclk;
      ld_ff     <= nxt_ld;
      wr_ff     <= nxt_wr;
      req_ff    <= nxt_req;
    end
  end

  // Outputs; SDO driven only in the data byte of a read
  assign rd_addr  = cmd_ff[5:0];
  assign wr_valid = wr_ff;
  assign wr_req   = req_ff;
  assign sdo      = tx_ff[7];
  assign sdo_oe_n = ~(~csb_n && cnt_ff >= SPI_CMD_BITS && !cmd_ff[CMD_WRITE_BIT]);
endmodule // uac_spi_target

/* sim/uac_config_regs_bench.sv */
// Self-checking bench of the configuration bank
`timescale 1ns/100ps
module uac_config_regs_bench;
  import uac_pkg::*;
  localparam int LC = 200;
  logic        clk, srst, trig, rx_ev, pin, err_clr, st_clr, stop, busy, done, tclk, err, err_n;
  logic [2:0]  tdiv;
  logic [7:0]  rd;
  logic [7:0]  mtab [3] = '{8'h12, 8'h11, 8'h1e};
  wire         sclk, csb_n, sdi, sdo, sdo_oe_n, sdo_line;
  uac_cfg_type cfg;
  int          bad_count, n_compared, n_stop, n_done, n_tclk;
  // Resolved data line seen by the host
  assign sdo_line = sdo_oe_n ? 1'bz : sdo;
  uac_config_regs #(.LISTEN_CYCLES(LC)) i_uac_config_regs (
    .SYS_CLK(clk), .SRST(srst), .SPI_SCLK(sclk), .SPI_CSB_N(csb_n), .SPI_SDI(sdi),
    .SPI_SDO(sdo), .SPI_SDO_OE_N(sdo_oe_n), .MEAS_TRIGGER(trig), .RX_EVENT(rx_ev),
    .CHANNEL_SELECT_PIN(pin), .TRANSMIT_DIVIDER(tdiv), .ERROR_CLEAR(err_clr),
    .STATE_CLEAR(st_clr), .ACTIVE_CFG(cfg), .STOP_PULSE(stop), .MEAS_BUSY(busy),
    .MEAS_DONE(done), .TEMP_CLK_EN(tclk), .ERROR_FLAG(err), .ERROR_OUTPUT_LOW_N(err_n));
  uac_host_model i_uac_host_model (.clk(clk), .sdo(sdo_line), .sclk(sclk), .csb_n(csb_n),
    .sdi(sdi));
  // Clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Strobe counters, sampled mid-cycle
  always @(negedge clk) begin
    n_stop += (stop === 1'b1);
    n_done += (done === 1'b1);
    n_tclk += (tclk === 1'b1);
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_uac_host_model.xfer({2'b01, a}, d, 5'h10, rd);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] exp, input string what);
    i_uac_host_model.xfer({2'b00, a}, 8'h00, 5'h10, rd);
    chk(rd, exp, what);
  endtask
  // Trigger, nev echo events, wait for the window to close
  task automatic meas(input int nev);
    n_stop = 0;
    n_done = 0;
    n_tclk = 0;
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    repeat (2) @(posedge clk);
    repeat (nev) begin
      rx_ev <= 1'b1;
      @(posedge clk);
      rx_ev <= 1'b0;
      @(posedge clk);
    end
    for (int k = 0; k < LC + 20 && busy !== 1'b0; k++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  // Error and state clear, flag checked
  task automatic clr;
    @(posedge clk);
    err_clr <= 1'b1;
    st_clr  <= 1'b1;
    @(posedge clk);
    err_clr <= 1'b0;
    st_clr  <= 1'b0;
    @(negedge clk);
    chk({err, err_n}, 2'b01, "error clear");
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    test_done;
  end
  // Test sequence
  initial begin
    {srst, trig, rx_ev, pin, err_clr, st_clr, tdiv} = {1'b1, 5'h00, 3'h5};
    {bad_count, n_compared, n_stop, n_done, n_tclk} = '0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    chk(cfg, {8'h00, 3'h2, 1'b0, 3'h3, 3'h0, 6'h20}, "cfg reset");
    rdc(ADDR_AVG_RX, 8'h40, "reg1 reset");
    rdc(ADDR_CHAN_MODE, 8'h00, "reg2 reset");
    rdc(ADDR_TEMP_ECHO, 8'h03, "reg3 reset");
    wr(6'h05, 8'h5a);
    rdc(6'h05, 8'h00, "unmapped");
    i_uac_host_model.xfer({2'b01, ADDR_TEMP_ECHO}, 8'hff, 5'h0c, rd);
    rdc(ADDR_TEMP_ECHO, 8'h03, "short frame");
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_CHAN_MODE, {6'h00, m[1:0]});
      rdc(ADDR_CHAN_MODE, {6'h00, m[1:0]}, "flight mode");
    end
    // Every receive and averaging code
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_AVG_RX, {2'b01, c[2:0], c[2:0]});
      meas(c == 0 ? 32 : c);
      chk(cfg.expected_stops, c == 0 ? 6'h20 : {3'h0, c[2:0]}, "stops cfg");
      chk(cfg.average_cycle_code, c[2:0], "avg code");
      chk({n_stop, n_done[30:0], err}, {c == 0 ? 32 : c, 31'd1, 1'b0}, "stops out");
    end
    // Temperature run with every temperature/echo field nonzero, ending in timeout
    wr(ADDR_CHAN_MODE, 8'he4);
    wr(ADDR_TEMP_ECHO, 8'hfd);
    rdc(ADDR_TEMP_ECHO, 8'hfd, "reg3 rw");
    meas(0);
    chk({cfg.common_mode_ext, cfg.meas_temp, cfg.damping, cfg.channel}, 4'hf, "f2");
    chk(cfg[17:6], {2'b11, 3'h5, 1'b0, 3'h5, 3'h7}, "f3");
    chk({err, err_n, n_tclk != 0}, 3'b101, "timeout");
    clr;
    // Write during an open window waits for the next trigger
    wr(ADDR_CHAN_MODE, 8'h00);
    wr(ADDR_AVG_RX, 8'h49);
    fork
      meas(0);
      wr(ADDR_TEMP_ECHO, 8'h0f);
    join
    chk(cfg.echo_threshold_code, 3'h5, "mid run write");
    // Swap in mode two, no swap in mode one, pin select overrides
    for (int s = 0; s < 3; s++) begin
      wr(ADDR_CHAN_MODE, mtab[s]);
      clr;
      for (int k = 0; k < 4; k++) begin
        pin <= k[0];
        meas(1);
        chk(cfg.channel, s == 2 ? k[0] : s == 1 ? 1'b0 : k[1], "chan");
      end
    end
    chk({cfg.blanking, cfg.echo_threshold_code}, 4'hf, "applied at trigger");
    test_done;
  end
endmodule // uac_config_regs_bench

/* sim/uac_config_regs_properties.sv */
// Port checker of the configuration bank
`timescale 1ns/100ps
module uac_config_regs_chk
  import uac_pkg::*;
#(
  parameter int LISTEN_CYCLES = 20   // Receive window
) (
  input logic                 SYS_CLK,            // Clock
  input logic                 SRST,               // Reset
  input logic                 SPI_CSB_N,          // Select
  input logic                 SPI_SDO_OE_N,       // SDO enable
  input logic                 RX_EVENT,           // Echo event
  input logic                 MEAS_TRIGGER,       // Trigger
  input logic                 ERROR_CLEAR,        // Error clear
  input logic                 STATE_CLEAR,        // Abort
  input uac_pkg::uac_cfg_type ACTIVE_CFG,         // Applied settings
  input logic                 STOP_PULSE,         // Stop pulse
  input logic                 MEAS_BUSY,          // Window open
  input logic                 MEAS_DONE,          // Window complete
  input logic                 TEMP_CLK_EN,        // Temperature clock
  input logic                 ERROR_FLAG,         // Sticky error
  input logic                 ERROR_OUTPUT_LOW_N  // Error pin
);
  logic [15:0] busy_cnt_ff, nxt_busy_cnt;
  logic [5:0]  stop_cnt_ff, nxt_stop_cnt;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  // Window length and stop pulses so far
  always_comb begin
    nxt_busy_cnt = MEAS_BUSY ? busy_cnt_ff + 16'h0001 : 16'h0000;
    nxt_stop_cnt = MEAS_BUSY ? stop_cnt_ff + {5'h00, STOP_PULSE} : 6'h00;
  end
  // Counter registers
  always_ff @(posedge SYS_CLK) begin
    busy_cnt_ff <= SRST ? 16'h0000 : nxt_busy_cnt;
    stop_cnt_ff <= SRST ? 6'h00 : nxt_stop_cnt;
  end
  a_stop_after_event: assert property (STOP_PULSE |-> $past(RX_EVENT))
    else $error("stop pulse without event");
  a_done_count: assert property (MEAS_DONE |->
    stop_cnt_ff + 6'h01 == ACTIVE_CFG.expected_stops) else $error("stop count at done");
  a_timeout_len: assert property ($rose(ERROR_FLAG) |->
    !MEAS_BUSY && $past(busy_cnt_ff) == 16'(LISTEN_CYCLES) + $past(stop_cnt_ff))
    else $error("timeout length");
  a_err_pin: assert property (ERROR_OUTPUT_LOW_N != ERROR_FLAG)
    else $error("error pin polarity");
  a_err_sticky: assert property (ERROR_FLAG && !ERROR_CLEAR |=> ERROR_FLAG)
    else $error("error flag lost");
  a_err_clear: assert property (ERROR_CLEAR && !MEAS_BUSY && !$fell(MEAS_BUSY)
    |=> !ERROR_FLAG) else $error("error flag not cleared");
  a_trig_start: assert property ($rose(MEAS_TRIGGER) && !MEAS_BUSY && !STATE_CLEAR
    |=> $rose(MEAS_BUSY)) else $error("trigger not taken");
  a_cfg_hold: assert property ($changed(ACTIVE_CFG) |-> $rose(MEAS_BUSY))
    else $error("settings changed mid run");
  a_sdo_release: assert property (SPI_CSB_N |-> SPI_SDO_OE_N)
    else $error("sdo driven while deselected");
  a_temp_clk_gate: assert property (TEMP_CLK_EN |-> MEAS_BUSY && ACTIVE_CFG.meas_temp)
    else $error("temperature clock outside run");
  c_done: cover property (MEAS_DONE);
  c_timeout: cover property ($rose(ERROR_FLAG));
  c_temp_clk: cover property (TEMP_CLK_EN);
endmodule // uac_config_regs_chk

bind uac_config_regs uac_config_regs_chk #(.LISTEN_CYCLES(LISTEN_CYCLES)) i_uac_config_regs_chk (
  .SYS_CLK(SYS_CLK), .SRST(SRST), .SPI_CSB_N(SPI_CSB_N), .SPI_SDO_OE_N(SPI_SDO_OE_N),
  .RX_EVENT(RX_EVENT), .MEAS_TRIGGER(MEAS_TRIGGER), .ERROR_CLEAR(ERROR_CLEAR),
  .STATE_CLEAR(STATE_CLEAR), .ACTIVE_CFG(ACTIVE_CFG), .STOP_PULSE(STOP_PULSE),
  .MEAS_BUSY(MEAS_BUSY), .MEAS_DONE(MEAS_DONE), .TEMP_CLK_EN(TEMP_CLK_EN),
  .ERROR_FLAG(ERROR_FLAG), .ERROR_OUTPUT_LOW_N(ERROR_OUTPUT_LOW_N));

/* sim/uac_host_model.sv */
// Host serial master: command byte then one data byte
`timescale 1ns/100ps
module uac_host_model (
  input  logic clk,    // System clock
  input  logic sdo,    // Resolved serial data line
  output logic sclk,   // Serial clock, still outside frames
  output logic csb_n,  // Select, low active
  output logic sdi     // Serial data to device
);
  // Idle levels
  initial begin
    sclk  = 1'b0;
    csb_n = 1'b1;
    sdi   = 1'b0;
  end
  // One frame, MSB first; fewer than 16 bits aborts it
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat,
                      input logic [4:0] nbits, output logic [7:0] rdat);
    logic [15:0] frame;
    frame = {cmd, dat};
    rdat  = 8'h00;
    @(posedge clk);
    csb_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk);
      sclk <= 1'b0;
      sdi  <= frame[15-i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      if (i >= 8) rdat[15-i] = sdo;
      repeat (2) @(posedge clk);
    end
    @(posedge clk);
    sclk  <= 1'b0;
    sdi   <= ~sdi;
    @(posedge clk);
    csb_n <= 1'b1;
    @(posedge clk);
  endtask
endmodule // uac_host_model
